/* File: sarseq_pkg.sv */
/*
 * Constants, register map and field layout of the successive-approximation
 * converter sequencer.
 * Assumes one 25 MHz clock and an analog core that samples, converts and
 * trims offset under the sequencer's control.
 */
// Functional notes
// [RULE1] Results at 8, 10 or 12 bits; 14 bits with averaging.
// [RULE2] Eight channels 0..7, each selecting any pin, supply or divided rail.
// [RULE3] Every result is a 16-bit two's complement value.
// [RULE4] Single-ended by default; negative input then grounded internally.
// [RULE5] Result scales by two to resolution minus m, m set by mode.
// [RULE6] Reference choice zero selects the internal reference.
// [RULE7] Offset trim task raises trim, conversion and result events.
// [RULE8] Non-zero positive selection picks the input and enables the channel.
// [RULE9] Negative selection only matters on differential channels.
// [RULE10] One enabled channel gives one-shot; two or more give scan.
// [RULE11] Software never combines scan with averaging.
// [RULE12] Status shows a conversion in progress, dropping after each one.
// [RULE13] Sample task connects the capacitor for acquisition time, then converts.
// [RULE14] Conversion event once per individual sample in every mode.
// [RULE15] Without averaging the result event coincides with conversion event.
// [RULE16] Internal pacing: one sample task repeats at the period; stop ends it.
// [RULE17] Software uses one channel only with internal pacing.
// [RULE18] Trigger rate stays below one over acquisition plus conversion time.
// [RULE19] Averaging gathers two to the N samples per stored result.
// [RULE20] Burst flag takes all averaging samples back to back on one task.
// [RULE21] With averaging the result event waits for a complete average.
// [RULE22] Software never shares an analog pin with the comparator.
// [RULE23] In scan each sample task converts every enabled channel once.
// [RULE24] Buffer-full event at capacity; samples sign-extended to 16 bits.
// [RULE25] Stop task ends sampling and always raises the halted event.
// [RULE26] Averaged result is the sum divided by two to the N.
// [RULE27] Scan visits enabled channels in ascending index order.
package sarseq_pkg;
    // --------
    // Register byte addresses
    // --------
    localparam logic [7:0] ADR_CH0 = 8'h00;
    localparam logic [7:0] ADR_RES = 8'h20;
    localparam logic [7:0] ADR_AVG = 8'h24;
    localparam logic [7:0] ADR_RATE = 8'h28;
    localparam logic [7:0] ADR_CAP = 8'h2c;
    localparam logic [7:0] ADR_STAT = 8'h30;
    localparam logic [7:0] ADR_AMT = 8'h34;
    localparam logic [7:0] ADR_LAST = 8'h38;
    // --------
    // Channel configuration fields
    // --------
    localparam int CFG_W = 14;
    localparam int PSEL_LSB = 0;
    localparam int NSEL_LSB = 4;
    localparam int SEL_W = 4;
    localparam int DIFF_BIT = 8;
    localparam int BURST_BIT = 9;
    localparam int ACQUISITION_TIME_LSB = 10;
    localparam int REF_BIT = 13;
    localparam logic [CFG_W-1:0] CFG_RST = 14'h0000;
    // Input selection codes: 1..8 analog pins, then supply and rail fifth.
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] SEL_SUPPLY = 4'h9;
    localparam logic [3:0] SEL_HIGH_RAIL_FIFTH = 4'ha;
    localparam logic [3:0] SEL_GND = 4'hf;
    // --------
    // Other fields and limits
    // --------
    localparam logic [1:0] RES_RST = 2'h1;
    localparam logic [3:0] AVG_MAX = 4'h8;
    localparam int PER_W = 11;
    localparam int RATE_MODE_BIT = 12;
    localparam int CAP_W = 15;
    localparam int FULL_SCALE_BITS = 14;
    // --------
    // Timing
    // --------
    localparam int CLK_HZ = 25_000_000;
    localparam int ACQUISITION_TIME_US [0:5] = '{3, 5, 10, 15, 20, 40};

    // Acquisition codes above five fall back to the longest time.
    function automatic logic [10:0] acquisition_time_cycles(input logic [2:0] code);
        int idx;
        idx = (code > 3'h5) ? 5 : int'(code);
        return 11'(ACQUISITION_TIME_US[idx] * (CLK_HZ / 1_000_000));
    endfunction : acquisition_time_cycles

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACQ = 5'b00010,
        ST_CONV = 5'b00100,
        ST_TRIM = 5'b01000,
        ST_PACE = 5'b10000
    } sarseq_state_e;
endpackage : sarseq_pkg

/* File: sarseq_top.sv */
/*
 * Sequencer of the successive-approximation converter: register file,
 * channel scan, acquisition timing, averaging, pacing and events.
 * Assumes tasks are one-cycle pulses synchronous to I_CLK, and that the
 * analog core returns a signed code at 14-bit single-ended scale.
 */
`timescale 1ns/1ps
module sarseq_top (
    input wire logic I_CLK, // 25 MHz clock.
    input wire logic I_RST_N, // Synchronous reset, active low.
    input wire logic [7:0] I_ADDR, // Register byte address.
    input wire logic [31:0] I_WDATA, // Write data.
    input wire logic I_WR, // Write strobe.
    input wire logic I_RD, // Read strobe.
    output logic [31:0] O_RDATA, // Read data, cycle after strobe.
    input wire logic I_TASK_START, // Rearm the result buffer.
    input wire logic I_TASK_SAMPLE, // Convert trigger.
    input wire logic I_TASK_STOP, // Stop sampling.
    input wire logic I_TASK_TRIM, // Offset trim request.
    output logic O_CORE_SAMPLE, // Sampling capacitor connected.
    output logic O_CORE_CONVERT, // Core converting.
    output logic [3:0] O_CORE_PSEL, // Positive input to core.
    output logic [3:0] O_CORE_NSEL, // Negative input to core.
    output logic O_CORE_REF, // Reference choice to core.
    output logic O_CORE_DIFF, // Differential mode to core.
    input wire logic I_CORE_DONE, // Core conversion finished.
    input wire logic [15:0] I_CORE_CODE, // Signed core code.
    output logic O_TRIM_REQ, // Offset trim running.
    input wire logic I_TRIM_DONE, // Offset trim finished.
    output logic O_RES_VALID, // Result word to DMA path.
    output logic [15:0] O_RES_DATA, // Result, two's complement.
    output logic [2:0] O_RES_CHAN, // Channel of the result.
    output logic O_EV_DONE, // One sample taken.
    output logic O_EV_RESULT, // Result stored.
    output logic O_EV_TRIM, // Offset trim complete.
    output logic O_EV_FULL, // Buffer capacity reached.
    output logic O_EV_HALT // Sampling halted.
);
    import sarseq_pkg::*;

    // --------
    // Configuration registers
    // --------
    logic [CFG_W-1:0] ch_cfg_reg [8];
    logic [CFG_W-1:0] ch_cfg_next [8];
    logic [1:0] res_reg, res_next;
    logic [3:0] avg_reg, avg_next;
    logic rate_mode_reg, rate_mode_next;
    logic [PER_W-1:0] per_reg, per_next;
    logic [CAP_W-1:0] cap_reg, cap_next;

    // Writes to unmapped addresses are dropped.
    always_comb begin
        ch_cfg_next = ch_cfg_reg;
        res_next = res_reg;
        avg_next = avg_reg;
        rate_mode_next = rate_mode_reg;
        per_next = per_reg;
        cap_next = cap_reg;
        if (I_WR) begin
            if (I_ADDR < ADR_RES && I_ADDR[1:0] == 2'h0) begin
                ch_cfg_next[I_ADDR[4:2]] = I_WDATA[CFG_W-1:0]; // RULE2
            end
            if (I_ADDR == ADR_RES) begin
                res_next = I_WDATA[1:0]; // RULE1
            end
            if (I_ADDR == ADR_AVG) begin
                avg_next = (I_WDATA[3:0] > AVG_MAX) ? AVG_MAX : I_WDATA[3:0];
            end
            if (I_ADDR == ADR_RATE) begin
                per_next = I_WDATA[PER_W-1:0];
                rate_mode_next = I_WDATA[RATE_MODE_BIT];
            end
            if (I_ADDR == ADR_CAP) begin
                cap_next = I_WDATA[CAP_W-1:0];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < 8; i++) begin
                ch_cfg_reg[i] <= CFG_RST;
            end
            res_reg <= RES_RST;
            avg_reg <= 4'h0;
            rate_mode_reg <= 1'b0;
            per_reg <= '0;
            cap_reg <= '0;
        end else begin
            ch_cfg_reg <= ch_cfg_next;
            res_reg <= res_next;
            avg_reg <= avg_next;
            rate_mode_reg <= rate_mode_next;
            per_reg <= per_next;
            cap_reg <= cap_next;
        end
    end

    // --------
    // Channel enables and scan order
    // --------
    logic [7:0] chan_en;
    logic [2:0] cur_reg, cur_next;

    // A channel is enabled purely by a non-zero positive selection.
    for (genvar g = 0; g < 8; g++) begin : g_en
        assign chan_en[g] = ch_cfg_reg[g][PSEL_LSB +: SEL_W] != SEL_NONE; // RULE8
    end

    logic scan_mode;
    logic [2:0] first_idx, nxt_idx;
    logic nxt_found;

    // Two or more set bits mean scan; ascending order via priority search.
    assign scan_mode = (chan_en & (chan_en - 8'h01)) != 8'h00; // RULE10
    always_comb begin
        first_idx = 3'h0;
        nxt_idx = 3'h0;
        nxt_found = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (chan_en[i]) begin
                first_idx = 3'(i); // RULE27
            end
            if (chan_en[i] && i > int'(cur_reg)) begin
                nxt_idx = 3'(i); // RULE27
                nxt_found = 1'b1;
            end
        end
    end

    // --------
    // Sequencer
    // --------
    sarseq_state_e state_reg, state_next;
    logic [10:0] acq_reg, acq_next;
    logic [PER_W-1:0] pace_reg, pace_next;
    logic pace_on_reg, pace_on_next;
    logic [7:0] avg_cnt_reg, avg_cnt_next;
    logic [23:0] acc_reg, acc_next;
    logic busy_reg, busy_next;
    logic [CAP_W-1:0] amt_reg, amt_next;
    logic full_reg, full_next;
    logic res_v_reg, res_v_next;
    logic [15:0] res_reg_d, res_d_next;
    logic [2:0] res_ch_reg, res_ch_next;
    logic ev_done_reg, ev_done_next;
    logic ev_res_reg, ev_res_next;
    logic ev_trim_reg, ev_trim_next;
    logic ev_full_reg, ev_full_next;
    logic ev_halt_reg, ev_halt_next;

    logic [CFG_W-1:0] cur_cfg;
    logic cur_diff;
    logic [4:0] shift;
    logic [15:0] sample;
    logic [23:0] sum;
    logic [7:0] avg_mask;
    logic pace_tick;

    assign cur_cfg = ch_cfg_reg[cur_reg];
    assign cur_diff = cur_cfg[DIFF_BIT];
    // Drop to the selected resolution; a differential channel loses one bit.
    assign shift = 5'(FULL_SCALE_BITS) - {2'h0, res_reg, 1'b0} - 5'h8
        + {4'h0, cur_diff}; // RULE5
    assign sample = 16'($signed(I_CORE_CODE) >>> shift); // RULE3
    assign sum = acc_reg + {{8{sample[15]}}, sample}; // RULE24
    // Averaging is forced off in scan so channels never mix in one sum.
    assign avg_mask = scan_mode ? 8'h00
        : 8'((9'h001 << avg_reg) - 9'h001); // RULE19
    assign pace_tick = pace_on_reg && pace_reg == '0;

    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        acq_next = acq_reg;
        pace_next = pace_reg;
        pace_on_next = pace_on_reg;
        avg_cnt_next = avg_cnt_reg;
        acc_next = acc_reg;
        amt_next = amt_reg;
        full_next = full_reg;
        res_v_next = 1'b0;
        res_d_next = res_reg_d;
        res_ch_next = res_ch_reg;
        ev_done_next = 1'b0;
        ev_res_next = 1'b0;
        ev_trim_next = 1'b0;
        ev_full_next = 1'b0;
        ev_halt_next = 1'b0;
        busy_next = 1'b0;
        // The pacing counter runs free while armed, so the rate is exact.
        if (pace_on_reg) begin
            pace_next = pace_tick ? per_reg - 11'h001 : pace_reg - 11'h001; // RULE16
        end
        if (I_TASK_START) begin
            amt_next = '0;
            full_next = 1'b0;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (I_TASK_TRIM) begin
                    state_next = ST_TRIM; // RULE7
                end else if (I_TASK_SAMPLE && chan_en != 8'h00) begin
                    state_next = ST_ACQ; // RULE13
                    cur_next = first_idx;
                    if (rate_mode_reg && !scan_mode) begin
                        pace_on_next = 1'b1; // RULE16
                        pace_next = per_reg - 11'h001;
                    end
                end
            end
            ST_PACE: begin
                if (pace_tick) begin
                    state_next = ST_ACQ; // RULE16
                    cur_next = first_idx;
                end
            end
            ST_ACQ: begin
                if (acq_reg == 11'h000) begin
                    state_next = ST_CONV; // RULE13
                end else begin
                    acq_next = acq_reg - 11'h001;
                end
            end
            ST_CONV: begin
                if (I_CORE_DONE) begin
                    ev_done_next = 1'b1; // RULE14
                    if (avg_cnt_reg != avg_mask) begin
                        acc_next = sum; // RULE19
                        avg_cnt_next = avg_cnt_reg + 8'h01;
                        if (cur_cfg[BURST_BIT]) begin
                            state_next = ST_ACQ; // RULE20
                        end else begin
                            state_next = pace_on_reg ? ST_PACE : ST_IDLE;
                        end
                    end else begin
                        acc_next = '0;
                        avg_cnt_next = 8'h00;
                        ev_res_next = 1'b1; // RULE15 RULE21
                        res_d_next = 16'($signed(sum) >>> (scan_mode ? 4'h0 : avg_reg)); // RULE26
                        res_ch_next = cur_reg;
                        if (!full_reg) begin
                            res_v_next = 1'b1;
                            amt_next = amt_reg + 15'h0001;
                            if (amt_reg + 15'h0001 == cap_reg) begin
                                full_next = 1'b1; // RULE24
                                ev_full_next = 1'b1; // RULE24
                            end
                        end
                        if (scan_mode && nxt_found) begin
                            state_next = ST_ACQ; // RULE23
                            cur_next = nxt_idx;
                        end else begin
                            state_next = pace_on_reg ? ST_PACE : ST_IDLE;
                        end
                    end
                end
            end
            ST_TRIM: begin
                if (I_TRIM_DONE) begin
                    state_next = ST_IDLE;
                    ev_trim_next = 1'b1; // RULE7
                    ev_done_next = 1'b1; // RULE7
                    ev_res_next = 1'b1; // RULE7
                end
            end
        endcase
        // Stop wins over every state change and reports even when already idle; a coinciding conversion end still raises its events.
        if (I_TASK_STOP) begin
            state_next = ST_IDLE; // RULE25
            pace_on_next = 1'b0; // RULE16
            acc_next = '0;
            avg_cnt_next = 8'h00;
            ev_halt_next = 1'b1; // RULE25
        end
        // Each entry into acquisition loads that channel's own time.
        if (state_next == ST_ACQ && state_reg != ST_ACQ) begin
            acq_next = acquisition_time_cycles(ch_cfg_reg[cur_next][ACQUISITION_TIME_LSB +: 3])
                - 11'h001; // RULE13
        end
        // Busy falls at the end of every conversion, for one cycle when another acquisition follows.
        busy_next = (state_next == ST_ACQ || state_next == ST_CONV
            || state_next == ST_TRIM) && !ev_done_next; // RULE12
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_reg <= ST_IDLE;
            cur_reg <= 3'h0;
            acq_reg <= 11'h000;
            pace_reg <= '0;
            pace_on_reg <= 1'b0;
            avg_cnt_reg <= 8'h00;
            acc_reg <= '0;
            busy_reg <= 1'b0;
            amt_reg <= '0;
            full_reg <= 1'b0;
            res_v_reg <= 1'b0;
            res_reg_d <= 16'h0000;
            res_ch_reg <= 3'h0;
            ev_done_reg <= 1'b0;
            ev_res_reg <= 1'b0;
            ev_trim_reg <= 1'b0;
            ev_full_reg <= 1'b0;
            ev_halt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            acq_reg <= acq_next;
            pace_reg <= pace_next;
            pace_on_reg <= pace_on_next;
            avg_cnt_reg <= avg_cnt_next;
            acc_reg <= acc_next;
            busy_reg <= busy_next;
            amt_reg <= amt_next;
            full_reg <= full_next;
            res_v_reg <= res_v_next;
            res_reg_d <= res_d_next;
            res_ch_reg <= res_ch_next;
            ev_done_reg <= ev_done_next;
            ev_res_reg <= ev_res_next;
            ev_trim_reg <= ev_trim_next;
            ev_full_reg <= ev_full_next;
            ev_halt_reg <= ev_halt_next;
        end
    end

    // --------
    // Read port
    // --------
    logic [31:0] rdata_reg, rdata_next;

    // Data stand only in the cycle after the strobe; unmapped reads give zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (I_RD) begin
            if (I_ADDR < ADR_RES && I_ADDR[1:0] == 2'h0) begin
                rdata_next = 32'(ch_cfg_reg[I_ADDR[4:2]]);
            end
            if (I_ADDR == ADR_RES) begin
                rdata_next = 32'(res_reg);
            end
            if (I_ADDR == ADR_AVG) begin
                rdata_next = 32'(avg_reg);
            end
            if (I_ADDR == ADR_RATE) begin
                rdata_next = 32'({rate_mode_reg, 1'b0, per_reg});
            end
            if (I_ADDR == ADR_CAP) begin
                rdata_next = 32'(cap_reg);
            end
            if (I_ADDR == ADR_STAT) begin
                rdata_next = 32'(busy_reg); // RULE12
            end
            if (I_ADDR == ADR_AMT) begin
                rdata_next = 32'(amt_reg);
            end
            if (I_ADDR == ADR_LAST) begin
                rdata_next = 32'(res_reg_d);
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // --------
    // Outputs
    // --------
    // Single-ended channels see ground on the negative side whatever is set.
    assign O_CORE_NSEL = cur_diff ? cur_cfg[NSEL_LSB +: SEL_W] : SEL_GND; // RULE4 RULE9
    assign O_CORE_PSEL = cur_cfg[PSEL_LSB +: SEL_W]; // RULE2
    assign O_CORE_REF = cur_cfg[REF_BIT]; // RULE6
    assign O_CORE_DIFF = cur_diff; // RULE4
    assign O_CORE_SAMPLE = state_reg == ST_ACQ; // RULE13
    assign O_CORE_CONVERT = state_reg == ST_CONV;
    assign O_TRIM_REQ = state_reg == ST_TRIM; // RULE7
    assign O_RDATA = rdata_reg;
    assign O_RES_VALID = res_v_reg;
    assign O_RES_DATA = res_reg_d;
    assign O_RES_CHAN = res_ch_reg;
    assign O_EV_DONE = ev_done_reg;
    assign O_EV_RESULT = ev_res_reg;
    assign O_EV_TRIM = ev_trim_reg;
    assign O_EV_FULL = ev_full_reg;
    assign O_EV_HALT = ev_halt_reg;
endmodule : sarseq_top

/* File: sarseq_assertions.sv */
/* Concurrent checks on the converter sequencer's task, core and event ports.
   Assumes the sequencer top and its package; attached by the bind below. */
`timescale 1ns/1ps
module sarseq_chk
    import sarseq_pkg::*;
(
    input wire logic I_CLK, // Clock.
    input wire logic I_RST_N, // Reset, active low.
    input wire logic I_TASK_STOP, // Stop task.
    input wire logic I_CORE_DONE, // Core finished.
    input wire logic I_TRIM_DONE, // Trim finished.
    input wire logic O_CORE_SAMPLE, // Acquisition.
    input wire logic O_CORE_CONVERT, // Conversion.
    input wire logic [3:0] O_CORE_NSEL, // Negative input.
    input wire logic O_CORE_DIFF, // Differential.
    input wire logic O_TRIM_REQ, // Trim running.
    input wire logic O_RES_VALID, // Result word.
    input wire logic O_EV_DONE, // Sample event.
    input wire logic O_EV_RESULT, // Result event.
    input wire logic O_EV_TRIM, // Trim event.
    input wire logic O_EV_HALT // Halt event.
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // A conversion ends when the core answers and no stop overrides it.
    sequence s_conv_end;
        O_CORE_CONVERT && I_CORE_DONE && !I_TASK_STOP;
    endsequence
    sequence s_trim_end;
        O_TRIM_REQ && I_TRIM_DONE && !I_TASK_STOP;
    endsequence
    chk_halt_after_stop: assert property (I_TASK_STOP |=> O_EV_HALT)
        else $error("halt event missing after stop");
    chk_stop_quiets_core: assert property (I_TASK_STOP |=>
        !O_CORE_SAMPLE && !O_CORE_CONVERT && !O_TRIM_REQ)
        else $error("core still busy after stop");
    chk_done_per_sample: assert property (s_conv_end |=> O_EV_DONE)
        else $error("sample event missing");
    chk_result_with_done: assert property (O_EV_RESULT |-> O_EV_DONE)
        else $error("result event without sample event");
    chk_word_with_events: assert property (O_RES_VALID |-> O_EV_RESULT && O_EV_DONE)
        else $error("result word without events");
    chk_trim_events: assert property (s_trim_end |=>
        O_EV_TRIM && O_EV_DONE && O_EV_RESULT)
        else $error("trim events incomplete");
    chk_single_ground: assert property (O_CORE_SAMPLE && !O_CORE_DIFF |->
        O_CORE_NSEL == SEL_GND)
        else $error("negative input not grounded");
    chk_acq_holds: assert property (disable iff (!I_RST_N || I_TASK_STOP)
        $rose(O_CORE_SAMPLE) |=> O_CORE_SAMPLE[*8])
        else $error("acquisition too short");
    chk_conv_after_acq: assert property ($rose(O_CORE_CONVERT) |-> $past(O_CORE_SAMPLE))
        else $error("conversion without acquisition");
endmodule : sarseq_chk

bind sarseq_top sarseq_chk sarseq_chk_i (.*);

/* File: sarseq_core_model.sv */
/* Behavioural analog core: answers a conversion or an offset trim a few
   clocks after the sequencer asks. Assumes the sequencer's clock. */
`timescale 1ns/1ps
module sarseq_core_model (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic convert, // Conversion request.
    input wire logic trim_req, // Trim request.
    input wire logic [15:0] val, // Code to return.
    output logic done, // Conversion finished.
    output logic trim_done, // Trim finished.
    output logic [15:0] code // Code, valid with done.
);
    logic [2:0] cnt;
    // Outside the answer cycle the code is inverted, so a stale capture shows.
    assign code = done ? val : ~val;
    // Fixed answer delay; the count parks so each request is answered once.
    always_ff @(posedge clk) begin
        done <= 1'h0;
        trim_done <= 1'h0;
        if (!rst_n || !(convert || trim_req)) begin
            cnt <= 3'h0;
        end else if (cnt == 3'h3) begin
            done <= convert;
            trim_done <= trim_req;
            cnt <= 3'h4;
        end else if (cnt < 3'h3) begin
            cnt <= cnt + 3'h1;
        end
    end
endmodule : sarseq_core_model

/* File: tb_sarseq_top.sv */
/* Self-checking bench of the converter sequencer with a core model.
   Assumes the sequencer top, its package and the core model. */
`timescale 1ns/1ps
module tb_sarseq_top;
    import sarseq_pkg::*;
    logic I_CLK = 1'h0, I_RST_N = 1'h0, I_WR = 1'h0, I_RD = 1'h0;
    logic I_TASK_START = 1'h0, I_TASK_SAMPLE = 1'h0, I_TASK_STOP = 1'h0;
    logic I_TASK_TRIM = 1'h0, I_CORE_DONE, I_TRIM_DONE;
    logic [7:0] I_ADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0, O_RDATA;
    logic [15:0] I_CORE_CODE, O_RES_DATA, val = 16'hf120;
    logic [3:0] O_CORE_PSEL, O_CORE_NSEL;
    logic [2:0] O_RES_CHAN;
    logic O_CORE_SAMPLE, O_CORE_CONVERT, O_CORE_REF, O_CORE_DIFF, O_TRIM_REQ;
    logic O_RES_VALID, O_EV_DONE, O_EV_RESULT, O_EV_TRIM, O_EV_FULL, O_EV_HALT;
    int checks = 0, miscompares = 0, ndone = 0, nres = 0, ntrim = 0, nhalt = 0, nfull = 0;
    int acq = 0, alen = 0, n0, r0;
    logic [18:0] rq[$];
    logic [9:0] sel;
    sarseq_top sarseq_top_i (.*);
    sarseq_core_model sarseq_core_model_i (.clk(I_CLK), .rst_n(I_RST_N),
        .convert(O_CORE_CONVERT), .trim_req(O_TRIM_REQ), .val(val),
        .done(I_CORE_DONE), .trim_done(I_TRIM_DONE), .code(I_CORE_CODE));
    always #20 I_CLK = ~I_CLK;
    // Event counts, acquisition length and the result words with channel.
    always @(posedge I_CLK) begin
        ndone += int'(O_EV_DONE);
        nres += int'(O_EV_RESULT);
        ntrim += int'(O_EV_TRIM);
        nhalt += int'(O_EV_HALT);
        nfull += int'(O_EV_FULL);
        if (O_CORE_CONVERT) sel = {O_CORE_REF, O_CORE_DIFF, O_CORE_NSEL, O_CORE_PSEL};
        if (O_RES_VALID) rq.push_back({O_RES_CHAN, O_RES_DATA});
        if (O_CORE_SAMPLE) acq++;
        else if (acq > 0) begin
            alen = acq;
            acq = 0;
        end
    end
    // --------
    // Bus, task and compare helpers
    // --------
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task wr(input logic [7:0] a, input logic [31:0] d);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'h1;
        @(posedge I_CLK);
        I_WR <= 1'h0;
        @(posedge I_CLK);
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task rd(input logic [7:0] a, input logic [31:0] e);
        I_ADDR <= a;
        I_RD <= 1'h1;
        @(posedge I_CLK);
        I_RD <= 1'h0;
        @(posedge I_CLK);
        cmp(O_RDATA, e);
    endtask : rd
    task trig(input logic [3:0] m);
        {I_TASK_TRIM, I_TASK_STOP, I_TASK_SAMPLE, I_TASK_START} <= m;
        @(posedge I_CLK);
        {I_TASK_TRIM, I_TASK_STOP, I_TASK_SAMPLE, I_TASK_START} <= 4'h0;
        @(posedge I_CLK);
    endtask : trig
    // Bounded wait for a total of sample events, then let results land.
    task wait_n(input int n);
        for (int k = 0; k < 5000 && ndone < n; k++) @(posedge I_CLK);
        repeat (3) @(posedge I_CLK);
        cmp(32'(ndone), 32'(n));
    endtask : wait_n
    // --------
    // Scenarios
    // --------
    task t_oneshot;
        rd(ADR_RES, 32'h1);
        rd(8'h3c, 32'h0);
        wr(ADR_CH0, 32'h1);
        rd(ADR_CH0, 32'h1);
        n0 = ndone;
        r0 = nres;
        trig(4'h2);
        rd(ADR_STAT, 32'h1);
        wait_n(n0 + 1);
        cmp(32'(alen), 32'h4b);
        cmp(32'(nres - r0), 32'h1);
        cmp(32'(rq.pop_front()), 32'h0ff12);
        rd(ADR_STAT, 32'h0);
        $display("one-shot test done");
    endtask : t_oneshot
    task t_scan;
        wr(ADR_CH0, 32'h0);
        wr(8'h04, 32'h52);
        wr(8'h0c, 32'h2143);
        n0 = ndone;
        trig(4'h2);
        wait_n(n0 + 2);
        cmp(32'(rq.pop_front()), 32'h1ff12);
        cmp(32'(rq.pop_front()), 32'h3ff89);
        cmp(32'(sel), 32'h343);
        $display("scan test done");
    endtask : t_scan
    task t_avg;
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h0);
        wr(ADR_CH0, 32'h201);
        wr(ADR_AVG, 32'h2);
        wr(ADR_RES, 32'h3);
        val <= 16'h0123;
        n0 = ndone;
        r0 = nres;
        trig(4'h2);
        wait_n(n0 + 4);
        cmp(32'(nres - r0), 32'h1);
        cmp(32'(rq.pop_front()), 32'h0123);
        wr(ADR_AVG, 32'h0);
        $display("averaging test done");
    endtask : t_avg
    task t_pace;
        wr(ADR_CH0, 32'h1);
        wr(ADR_RATE, 32'h10c8);
        wr(ADR_CAP, 32'h5);
        n0 = ndone;
        r0 = nhalt;
        trig(4'h2);
        wait_n(n0 + 3);
        trig(4'h4);
        n0 = ndone;
        repeat (400) @(posedge I_CLK);
        cmp(32'(ndone), 32'(n0));
        trig(4'h4);
        repeat (2) @(posedge I_CLK);
        cmp(32'(nhalt - r0), 32'h2);
        cmp(32'(nfull), 32'h1);
        rd(ADR_AMT, 32'h5);
        $display("pacing test done");
    endtask : t_pace
    task t_trim;
        n0 = ndone;
        r0 = ntrim;
        trig(4'h8);
        wait_n(n0 + 1);
        cmp(32'(ntrim - r0), 32'h1);
        $display("trim test done");
    endtask : t_trim
    task conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Main sequence after five reset cycles.
    initial begin
        repeat (5) @(posedge I_CLK);
        I_RST_N <= 1'h1;
        @(posedge I_CLK);
        trig(4'h1);
        t_oneshot();
        t_scan();
        t_avg();
        t_pace();
        t_trim();
        conclude();
    end
    // Watchdog well beyond the roughly 1500 cycles the tests need.
    initial begin
        repeat (20000) @(posedge I_CLK);
        miscompares++;
        conclude();
    end
endmodule : tb_sarseq_top
